// ---- logic/touch_gate_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "touch_key_params.svh"
module touch_gate_counter
  import touch_key_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [15:0] window_len,
  // oscillator pin
  input  wire logic        osc_pin,
  // result
  output logic             busy,
  output logic             done_pulse,
  output count_type        count
);

  logic           osc_meta;
  logic           osc_sync;
  logic           osc_prev;
  logic           osc_rise;
  gate_state_type state;
  logic [15:0]    remain;
  count_type      running;

  // two-flop synchroniser, edge detector reads the second stage and its delayed copy osc_prev
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= osc_pin;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end
  assign osc_rise = osc_sync & ~osc_prev;

  // gate window of window_len clocks, oscillator edges counted inside it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= st_idle;
      remain     <= 16'h0000;
      running    <= 12'h000;
      done_pulse <= 1'b0;
      count      <= 12'h000;
    end else begin
      done_pulse <= 1'b0;
      unique case (state)
        st_idle: begin
          if (start && !abort) begin
            state   <= st_gate;
            remain  <= window_len;
            running <= 12'h000;
          end
        end
        st_gate: begin
          if (abort) begin
            state <= st_idle;
          end else if (remain == 16'h0000) begin
            state      <= st_idle;
            count      <= running;
            done_pulse <= 1'b1;
          end else begin
            remain <= remain - 16'h0001;
            // saturate rather than wrap so a slow window never reads small
            if (osc_rise && running != `COUNT_MAX) begin
              running <= running + 12'h001;
            end
          end
        end
      endcase
    end
  end

  assign busy = (state == st_gate);

endmodule
`default_nettype wire

// ---- logic/touch_key_params.svh ----
`ifndef TOUCH_KEY_PARAMS_SVH
`define TOUCH_KEY_PARAMS_SVH

// register indices, byte address is four times the index
`define IDX_IE_MAIN      8'ha8
`define IDX_IE_EXTRA     8'ha9
`define IDX_SHARED       8'haa
`define IDX_CONV_HIGH    8'hab
`define IDX_TOUCH_LOW    8'hac
`define IDX_CAP_TRIM     8'had
`define IDX_TOUCH_CTRL   8'hae
`define IDX_REF_LOW      8'hb4
`define IDX_REF_HIGH     8'hc0
`define IDX_IRQ_STATUS   8'hc1
`define IDX_IRQ_MASK     8'hc2

// field positions
`define BIT_GLOBAL_EN    3'd7
`define BIT_CONV_TOUCH   3'd3
`define BIT_POWER_DOWN   3'd7
`define BIT_DONE         3'd6
`define BIT_ST_TOUCH     1'd0
`define BIT_ST_CONV      1'd1

// writable masks and reset values
`define MASK_IE_MAIN     8'hbf
`define MASK_IE_EXTRA    8'h3f
`define RST_IE           8'h00
`define RST_CAP_TRIM     7'h40
`define RST_POWER_DOWN   1'b1
`define RST_CHANNEL      4'hf
`define RST_REF_LOW      8'hff
`define RST_REF_HIGH     8'h00
`define RST_IRQ          2'h0
`define COUNT_MAX        12'hfff

`endif

// ---- logic/touch_key_pkg.sv ----
package touch_key_pkg;
  // touch gate sequencer
  typedef enum logic [0:0] {
    st_idle,
    st_gate
  } gate_state_type;

  typedef logic [7:0]  byte_type;
  typedef logic [11:0] count_type;
endpackage

// ---- logic/touch_key_readout.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "touch_key_params.svh"
module touch_key_readout
  import touch_key_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // converter result, same clock domain
  input  wire logic [11:0] conv_data,
  input  wire logic        conv_done,
  // touch electrode oscillator, asynchronous
  input  wire logic        touch_osc,
  // analog front end controls
  output logic             touch_power_down,
  output logic [3:0]       touch_channel_select,
  output logic [6:0]       touch_cap_trim,
  // interrupt
  output logic             irq
);

  // ==========================================================
  // declarations
  // ==========================================================
  byte_type    interrupt_enable_main;
  byte_type    interrupt_enable_extra;
  byte_type    ref_low;
  byte_type    ref_high;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  count_type   conv_result;
  count_type   touch_count_result;
  logic        busy;
  logic        touch_done_pulse;
  logic        touch_conversion_done;
  logic        start_conv;
  logic [7:0]  idx;
  logic        aligned;
  logic        mapped;
  logic        setup;
  logic        wr_access;
  byte_type    wbyte;
  byte_type    rd_byte;
  logic [1:0]  next_irq_status;

  // ==========================================================
  // bus decode
  // ==========================================================
  assign idx       = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && mapped;
  assign wbyte     = pwdata[7:0];
  // zero wait states, data is staged in the setup cycle
  assign pready    = 1'b1;

  // mapped index check
  always_comb begin
    unique case (idx)
      `IDX_IE_MAIN, `IDX_IE_EXTRA, `IDX_SHARED, `IDX_CONV_HIGH,
      `IDX_TOUCH_LOW, `IDX_CAP_TRIM, `IDX_TOUCH_CTRL, `IDX_REF_LOW,
      `IDX_REF_HIGH, `IDX_IRQ_STATUS, `IDX_IRQ_MASK: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // interrupt enables
  // ==========================================================
  // unlisted enable bits read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_main  <= `RST_IE;
      interrupt_enable_extra <= `RST_IE;
    end else if (wr_access) begin
      if (idx == `IDX_IE_MAIN) begin
        interrupt_enable_main <= wbyte & `MASK_IE_MAIN;
      end
      if (idx == `IDX_IE_EXTRA) begin
        interrupt_enable_extra <= wbyte & `MASK_IE_EXTRA;
      end
    end
  end

  // ==========================================================
  // touch control and calibration
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touch_power_down     <= `RST_POWER_DOWN;
      touch_channel_select <= `RST_CHANNEL;
      touch_cap_trim       <= `RST_CAP_TRIM;
      ref_low              <= `RST_REF_LOW;
      ref_high             <= `RST_REF_HIGH;
    end else if (wr_access) begin
      if (idx == `IDX_TOUCH_CTRL) begin
        touch_power_down <= wbyte[`BIT_POWER_DOWN];
      end
      if (idx == `IDX_TOUCH_CTRL) begin
        touch_channel_select <= wbyte[3:0];
      end
      if (idx == `IDX_CAP_TRIM) begin
        touch_cap_trim <= wbyte[6:0];
      end
      if (idx == `IDX_REF_LOW) begin
        ref_low <= wbyte;
      end
      if (idx == `IDX_REF_HIGH) begin
        ref_high <= wbyte;
      end
    end
  end

  // writing the control register with power-down clear starts a count;
  // a write during a running count restarts nothing, it is ignored
  assign start_conv = wr_access && (idx == `IDX_TOUCH_CTRL) && !wbyte[`BIT_POWER_DOWN];

  // ==========================================================
  // touch counter
  // ==========================================================
  // power-down aborts and blocks counting
  touch_gate_counter u_counter (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (start_conv),
    .abort      (touch_power_down && !start_conv), // a starting write lifts power-down at the same edge
    .window_len ({ref_high, ref_low}),
    .osc_pin    (touch_osc),
    .busy       (busy),
    .done_pulse (touch_done_pulse),
    .count      (touch_count_result)
  );

  // done flag is the idle state, reset idle
  // start clears it, latch or power-down abort sets it
  assign touch_conversion_done = !busy;

  // ==========================================================
  // converter result capture
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_result <= 12'h000;
    end else if (conv_done) begin
      conv_result <= conv_data;
    end
  end

  // ==========================================================
  // interrupt status and output
  // ==========================================================
  // touch latch raises request; set wins over write-one clear
  always_comb begin
    next_irq_status = irq_status;
    if (wr_access && idx == `IDX_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wbyte[1:0];
    end
    if (touch_done_pulse) begin
      next_irq_status[`BIT_ST_TOUCH] = 1'b1;
    end
    if (conv_done) begin
      next_irq_status[`BIT_ST_CONV] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `RST_IRQ;
      irq_mask   <= `RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
      if (wr_access && idx == `IDX_IRQ_MASK) begin
        irq_mask <= wbyte[1:0];
      end
    end
  end

  assign irq = interrupt_enable_main[`BIT_GLOBAL_EN] && interrupt_enable_extra[`BIT_CONV_TOUCH]
               && |(irq_status & irq_mask);

  // ==========================================================
  // read mux and answer
  // ==========================================================
  always_comb begin
    unique case (idx)
      `IDX_IE_MAIN:    rd_byte = interrupt_enable_main;
      `IDX_IE_EXTRA:   rd_byte = interrupt_enable_extra;
      `IDX_SHARED:     rd_byte = {conv_result[3:0], touch_count_result[11:8]};
      `IDX_CONV_HIGH:  rd_byte = conv_result[11:4];
      `IDX_TOUCH_LOW:  rd_byte = touch_count_result[7:0];
      `IDX_CAP_TRIM:   rd_byte = {1'b0, touch_cap_trim};
      `IDX_TOUCH_CTRL: rd_byte = {touch_power_down, touch_conversion_done, 2'b00, touch_channel_select};
      `IDX_REF_LOW:    rd_byte = ref_low;
      `IDX_REF_HIGH:   rd_byte = ref_high;
      `IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status};
      `IDX_IRQ_MASK:   rd_byte = {6'h00, irq_mask};
      default:         rd_byte = 8'h00;
    endcase
  end

  // staged in setup so the access phase answers from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= (!pwrite && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= !mapped;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PD_STOPS_COUNT: assert property (
    touch_power_down && $past(touch_power_down) |-> !busy)
    else $error("touch count running while powered down");

  AST_START_CLEARS_DONE: assert property (
    start_conv && touch_conversion_done |=> !touch_conversion_done)
    else $error("done flag not cleared by start");

  // done rises with latch pulse, status follows a cycle later
  AST_DONE_WITH_LATCH: assert property (
    $rose(touch_conversion_done) && !touch_power_down |-> touch_done_pulse ##1 irq_status[`BIT_ST_TOUCH])
    else $error("done flag rose without result latch");

  AST_CHANNEL_WRITE: assert property (
    wr_access && idx == `IDX_TOUCH_CTRL |=> touch_channel_select == $past(pwdata[3:0]))
    else $error("channel select did not take written value");

  // shared low nibble holds touch high bits
  AST_SHARED_TOUCH: assert property (
    setup && !pwrite && mapped && idx == `IDX_SHARED
    |=> prdata[3:0] == $past(touch_count_result[11:8]) && prdata[31:8] == 24'h00_0000)
    else $error("shared register touch nibble wrong");

  AST_TOUCH_LOW: assert property (
    setup && !pwrite && mapped && idx == `IDX_TOUCH_LOW |=> prdata[7:0] == $past(touch_count_result[7:0]))
    else $error("touch low byte readback wrong");

  AST_SHARED_CONV: assert property (
    conv_done ##1 (setup && !pwrite && mapped && idx == `IDX_SHARED && !conv_done)
    |=> prdata[7:4] == $past(conv_data[3:0], 2))
    else $error("shared register converter nibble wrong");

  AST_CONV_HIGH: assert property (
    setup && !pwrite && mapped && idx == `IDX_CONV_HIGH |=> prdata[7:0] == $past(conv_result[11:4]))
    else $error("converter high byte readback wrong");

  AST_TRIM_WRITE: assert property (
    wr_access && idx == `IDX_CAP_TRIM |=> touch_cap_trim == $past(pwdata[6:0]))
    else $error("capacitance trim not updated");

  AST_IRQ_NEEDS_SOURCE: assert property (
    irq |-> interrupt_enable_extra[`BIT_CONV_TOUCH] && |(irq_status & irq_mask))
    else $error("interrupt without source enable");

  AST_IRQ_NEEDS_GLOBAL: assert property (
    !interrupt_enable_main[`BIT_GLOBAL_EN] |-> !irq)
    else $error("interrupt with global enable clear");

  AST_REF_LOW_WRITE: assert property (
    wr_access && idx == `IDX_REF_LOW |=> ref_low == $past(pwdata[7:0]))
    else $error("reference low byte not updated");

  AST_PD_WRITE: assert property (
    wr_access && idx == `IDX_TOUCH_CTRL |=> touch_power_down == $past(pwdata[`BIT_POWER_DOWN]))
    else $error("power-down bit did not take written value");

  AST_PD_NO_RESULT: assert property (
    touch_power_down && $past(touch_power_down) |-> !touch_done_pulse)
    else $error("touch result latched while powered down");

  AST_DONE_READBACK: assert property (
    setup && !pwrite && mapped && idx == `IDX_TOUCH_CTRL |=> prdata[`BIT_DONE] == $past(touch_conversion_done))
    else $error("done flag readback wrong");

  AST_LATCH_SETS_STATUS: assert property (
    touch_done_pulse |=> irq_status[`BIT_ST_TOUCH])
    else $error("touch status not set by result latch");

  // request raised at latch when enabled
  AST_LATCH_RAISES_IRQ: assert property (
    touch_done_pulse && !wr_access && interrupt_enable_main[`BIT_GLOBAL_EN]
    && interrupt_enable_extra[`BIT_CONV_TOUCH] && irq_mask[`BIT_ST_TOUCH] |=> irq)
    else $error("interrupt not raised at result latch");

  AST_COUNT_HOLDS: assert property (
    !touch_done_pulse |-> $stable(touch_count_result))
    else $error("touch count changed without a latch");

  AST_IRQ_EXTRA_GATE: assert property (
    !interrupt_enable_extra[`BIT_CONV_TOUCH] |-> !irq)
    else $error("interrupt with source enable clear");

  // converter pulse sets its status bit
  AST_CONV_SETS_STATUS: assert property (
    conv_done |=> irq_status[`BIT_ST_CONV])
    else $error("converter status not set");

  // unmapped access answers with an error and zero data
  AST_UNMAPPED_ERR: assert property (
    setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access without error");

  COV_TOUCH_DONE: cover property (start_conv ##[1:1000] touch_done_pulse);
  COV_IRQ_RISE:   cover property ($rose(irq));
  COV_CONV_DONE:  cover property (conv_done ##1 (setup && idx == `IDX_CONV_HIGH));
  COV_UNMAPPED:   cover property (setup && !mapped);

endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import touch_key_pkg::*;
;
  // =====================================================
  // signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [11:0] conv_data = 12'h000;
  logic        conv_done = 1'b0;
  logic        touch_osc;
  logic        touch_power_down;
  logic [3:0]  touch_channel_select;
  logic [6:0]  touch_cap_trim;
  logic        irq;
  int          err_count = 0;
  int          checks = 0;

  // 25 MHz
  always #20 pclk = ~pclk;

  touch_key_readout i_touch_key_readout (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .conv_data(conv_data), .conv_done(conv_done), .touch_osc(touch_osc), .touch_power_down(touch_power_down),
    .touch_channel_select(touch_channel_select), .touch_cap_trim(touch_cap_trim), .irq(irq));

  touch_electrode_model i_touch_electrode_model (.power_down(touch_power_down), .osc(touch_osc));

  // =====================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_range(input string what, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] got);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      err_count++;
      $display("BAD %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask

  // master waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here, the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
    // written registers update after the access edge, look once settled
    @(negedge pclk);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk(what, exp, rd);
  endtask

  // irq is combinational, look once the edge has settled
  task automatic chk_irq(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  task automatic conv_pulse(input logic [11:0] val);
    @(posedge pclk);
    conv_data <= val;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask

  // =====================================================
  // scenarios
  task automatic test_reset;
    rd_chk("control", 8'hae, 32'hcf);
    rd_chk("trim", 8'had, 32'h40);
    rd_chk("ref_low", 8'hb4, 32'hff);
    rd_chk("main_en", 8'ha8, 32'h0);
    rd_chk("extra_en", 8'ha9, 32'h0);
    chk("pd_pin", 32'h1, {31'h0, touch_power_down});
    chk("chan_pin", 32'hf, {28'h0, touch_channel_select});
    chk("trim_pin", 32'h40, {25'h0, touch_cap_trim});
    chk_irq(1'b0);
    $display("test reset done");
  endtask

  task automatic test_regs;
    logic [31:0] rd;
    logic        err;
    wr(8'had, 8'hff);
    rd_chk("trim_max", 8'had, 32'h7f);
    chk("trim_pin", 32'h7f, {25'h0, touch_cap_trim});
    wr(8'had, 8'h00);
    chk("trim_pin", 32'h0, {25'h0, touch_cap_trim});
    // every channel code, powered down so nothing starts
    for (int c = 0; c < 16; c++) begin
      wr(8'hae, {4'h8, c[3:0]});
      chk("chan_pin", {28'h0, c[3:0]}, {28'h0, touch_channel_select});
      rd_chk("control", 8'hae, {24'h0, 4'hc, c[3:0]});
    end
    apb(1'b0, 8'h10, 8'h00, rd, err);
    chk("unmapped_rd", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, err});
    $display("test regs done");
  endtask

  // a short window keeps the count well inside the low byte
  task automatic test_touch;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] ctl;
    logic        err;
    int          n;
    wr(8'had, 8'h40); // trim back to mid scale before counting
    wr(8'hb4, 8'h20);
    rd_chk("ref_low", 8'hb4, 32'h20);
    wr(8'hc1, 8'h03);
    wr(8'hc2, 8'h01);
    wr(8'ha9, 8'h08);
    wr(8'ha8, 8'h80);
    // first start straight out of power-down
    wr(8'hae, 8'h05);
    chk("pd_pin", 32'h0, {31'h0, touch_power_down});
    rd_chk("busy_ctl", 8'hae, 32'h05);
    n = 0;
    do begin
      apb(1'b0, 8'hae, 8'h00, ctl, err);
      n++;
    end while (ctl[6] !== 1'b1 && n < 40);
    chk("done_ctl", 32'h45, ctl);
    apb(1'b0, 8'hac, 8'h00, lo, err);
    apb(1'b0, 8'haa, 8'h00, hi, err);
    chk_range("touch_count", 32'd5, 32'd11, {20'h0, hi[3:0], lo[7:0]});
    rd_chk("status", 8'hc1, 32'h1);
    chk_irq(1'b1);
    wr(8'hc1, 8'h01);
    chk_irq(1'b0);
    // power down in mid count aborts without a result
    wr(8'hae, 8'h05);
    wr(8'hae, 8'h85);
    rd_chk("abort_ctl", 8'hae, 32'hc5);
    rd_chk("abort_st", 8'hc1, 32'h0);
    rd_chk("count_kept", 8'hac, lo);
    $display("test touch done");
  endtask

  task automatic test_conv_irq;
    logic [31:0] rd;
    logic        err;
    wr(8'ha8, 8'h00);
    wr(8'hc2, 8'h02);
    conv_pulse(12'habc);
    rd_chk("shared", 8'haa, 32'hc0);
    rd_chk("conv_high", 8'hab, 32'hab);
    apb(1'b1, 8'hab, 8'h55, rd, err);
    chk("ro_err", 32'h0, {31'h0, err});
    rd_chk("ro_kept", 8'hab, 32'hab);
    chk_irq(1'b0);
    wr(8'ha8, 8'h80);
    chk_irq(1'b1);
    wr(8'ha9, 8'h00);
    chk_irq(1'b0);
    wr(8'ha9, 8'h08);
    chk_irq(1'b1);
    wr(8'hc1, 8'h02);
    chk_irq(1'b0);
    $display("test conv irq done");
  endtask

  // =====================================================
  // run and verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_regs();
    test_touch();
    test_conv_irq();
    finish_test();
  end

  // the whole run needs well under 3000 cycles
  initial begin
    #800000;
    err_count++;
    $display("BAD watchdog expected end seen timeout");
    finish_test();
  end
endmodule
`default_nettype wire

// ---- verif/touch_electrode_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// electrode oscillator
module touch_electrode_model #(
  parameter int HALF_NS = 83
) (
  // control from the device
  input  wire logic power_down,
  // oscillator pin
  output var  logic osc
);
  initial osc = 1'b0;
  // idle while powered down
  // odd half period keeps the pin out of phase with pclk
  always begin
    #(HALF_NS);
    if (power_down === 1'b0) osc = ~osc;
    else osc = 1'b0;
  end
endmodule
`default_nettype wire
